/* File: rtl/amm_mailbox.sv */
// module: alarm-acknowledge and configuration-mismatch mailbox engine
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module amm_mailbox
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // network controller events
  input wire logic alarm_ack_event,
  input wire logic [15:0] alarm_ack_handle,
  output logic alarm_ack_ready,
  input wire logic mismatch_event,
  input wire amm_pkg::amm_mismatch_t mismatch_info,
  output logic mismatch_ready,
  // indication frames to host
  output logic tx_valid,
  output logic [15:0] tx_word,
  input wire logic tx_ready,
  // response frames from host
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_word,
  output logic rsp_ready,
  // results
  output amm_pkg::amm_apply_t applied,
  output amm_pkg::amm_ident_t ident_record,
  output logic [15:0] record_len
);

  typedef struct packed {
    amm_pkg::amm_fsm_t fsm;
    logic [3:0] idx;
    logic [3:0] rx_idx;
    logic tx_valid;
    logic [15:0] tx_word;
    logic cur_mm;
    logic [15:0] msg_id;
    logic pend_al;
    logic [15:0] al_handle;
    logic pend_mm;
    amm_pkg::amm_mismatch_t mm;
    // copies taken at launch, so a new event cannot alter a frame in flight
    logic [15:0] cur_handle;
    amm_pkg::amm_mismatch_t cur_info;
    logic hdr_ok;
    logic [15:0] mod_state;
    logic [15:0] sub_state;
    logic [31:0] act_mod;
    logic [31:0] act_sub;
    amm_pkg::amm_apply_t app;
    logic [1:0] ctrl;
    amm_pkg::amm_ident_t ident;
    logic [15:0] rec_len;
    logic rsp_err;
    logic [31:0] rdata;
  } amm_state_t;

  amm_state_t st_r;
  amm_state_t st_nxt;

  // ******************************************************
  // frame word builder
  // ******************************************************
  function automatic logic [15:0] frame_word(
    input logic [3:0] idx,
    input logic is_mm,
    input logic [15:0] id,
    input logic [15:0] handle,
    input amm_pkg::amm_mismatch_t mm
  );
    logic [15:0] w;
    w = 16'h0000;
    case (idx)
      4'h0: w = id;
      4'h1: w = amm_pkg::MSG_INFO_IND;
      4'h2: w = is_mm ? amm_pkg::CMD_MISMATCH : amm_pkg::CMD_ALARM_ACK;
      4'h3: w = amm_pkg::DATA_SIZE_NONE;
      4'h4: w = amm_pkg::FRAME_ONE;
      4'h5: w = amm_pkg::FRAME_ONE;
      4'h8: w = is_mm ? mm.relationship_handle : handle;
      4'h9: w = is_mm ? mm.slot : 16'h0000;
      4'hA: w = is_mm ? mm.subslot : 16'h0000;
      4'hB: w = is_mm ? mm.des_mod[31:16] : 16'h0000;
      4'hC: w = is_mm ? mm.des_mod[15:0] : 16'h0000;
      4'hD: w = is_mm ? mm.des_sub[31:16] : 16'h0000;
      4'hE: w = is_mm ? mm.des_sub[15:0] : 16'h0000;
      default: w = 16'h0000; // offsets and unused words
    endcase
    return w;
  endfunction

  // ******************************************************
  // applied record builder
  // ******************************************************
  function automatic amm_pkg::amm_apply_t apply_rec(
    input amm_pkg::amm_mismatch_t info,
    input logic [15:0] mod_state,
    input logic [15:0] sub_state,
    input logic [31:0] mod_id,
    input logic [31:0] sub_id
  );
    amm_pkg::amm_apply_t a;
    a.valid = 1'b1;
    a.slot = info.slot;
    a.subslot = info.subslot;
    a.mod_state = mod_state;
    a.sub_state = sub_state;
    a.mod_id = mod_id;
    a.sub_id = sub_id;
    return a;
  endfunction

  // ******************************************************
  // next state
  // ******************************************************
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.app.valid = 1'b0;
    st_nxt.rdata = 32'h0000_0000;

    // ******************************************************
    // event capture
    // ******************************************************
    // events latch while enabled; disabled events are dropped
    if (alarm_ack_event && !st_r.pend_al && st_r.ctrl[amm_pkg::CTRL_ALARM_ACK_EN])
    begin
      st_nxt.pend_al = 1'b1;
      st_nxt.al_handle = alarm_ack_handle;
    end
    if (mismatch_event && !st_r.pend_mm && st_r.ctrl[amm_pkg::CTRL_MISMATCH_EN])
    begin
      st_nxt.pend_mm = 1'b1;
      st_nxt.mm = mismatch_info;
    end

    // ******************************************************
    // status clear
    // ******************************************************
    // clear first, so an error raised below in the same cycle wins
    if (reg_wr && (reg_addr == amm_pkg::OFF_STATUS) && reg_wdata[amm_pkg::ST_RSP_ERR])
    begin
      st_nxt.rsp_err = 1'b0;
    end

    // ******************************************************
    // frame sequencer and response parser
    // ******************************************************
    case (st_r.fsm)
      amm_pkg::S_IDLE:
      begin
        // alarm first: it needs no answer and frees the host sooner
        if (st_r.pend_al || st_r.pend_mm)
        begin
          st_nxt.cur_mm = !st_r.pend_al;
          st_nxt.cur_handle = st_r.al_handle;
          st_nxt.cur_info = st_r.mm;
          if (st_r.pend_al)
            st_nxt.pend_al = 1'b0;
          else
            st_nxt.pend_mm = 1'b0;
          st_nxt.msg_id = st_r.msg_id + 16'h0001;
          st_nxt.idx = 4'h0;
          st_nxt.tx_valid = 1'b1;
          st_nxt.tx_word = frame_word(4'h0, !st_r.pend_al, st_nxt.msg_id, st_r.al_handle, st_r.mm);
          st_nxt.fsm = amm_pkg::S_SEND;
        end
      end
      amm_pkg::S_SEND:
      begin
        if (tx_ready)
        begin
          if (st_r.idx == amm_pkg::FRAME_LAST)
          begin
            st_nxt.tx_valid = 1'b0;
            st_nxt.tx_word = 16'h0000;
            st_nxt.rx_idx = 4'h0;
            st_nxt.hdr_ok = 1'b1;
            // no response is awaited after an alarm indication
            st_nxt.fsm = st_r.cur_mm ? amm_pkg::S_WAIT : amm_pkg::S_IDLE;
          end
          else
          begin
            st_nxt.idx = st_r.idx + 4'h1;
            st_nxt.tx_word = frame_word(st_r.idx + 4'h1, st_r.cur_mm, st_r.msg_id, st_r.cur_handle, st_r.cur_info);
          end
        end
      end
      amm_pkg::S_WAIT:
      begin
        if (rsp_valid)
        begin
          st_nxt.rx_idx = st_r.rx_idx + 4'h1;
          case (st_r.rx_idx)
            amm_pkg::W_ID: st_nxt.hdr_ok = st_r.hdr_ok && (rsp_word == st_r.msg_id);
            amm_pkg::W_INFO: st_nxt.hdr_ok = st_r.hdr_ok && (rsp_word == amm_pkg::MSG_INFO_RSP);
            amm_pkg::W_CMD: st_nxt.hdr_ok = st_r.hdr_ok && (rsp_word == amm_pkg::CMD_MISMATCH);
            amm_pkg::W_MOD_STATE: st_nxt.mod_state = rsp_word;
            amm_pkg::W_SUB_STATE: st_nxt.sub_state = rsp_word;
            amm_pkg::W_ACT_MOD_HI: st_nxt.act_mod[31:16] = rsp_word;
            amm_pkg::W_ACT_MOD_LO: st_nxt.act_mod[15:0] = rsp_word;
            amm_pkg::W_ACT_SUB_HI: st_nxt.act_sub[31:16] = rsp_word;
            amm_pkg::W_ACT_SUB_LO: st_nxt.act_sub[15:0] = rsp_word;
            default: st_nxt.hdr_ok = st_r.hdr_ok;
          endcase
          if (st_r.rx_idx == amm_pkg::FRAME_LAST)
          begin
            st_nxt.rx_idx = 4'h0;
            st_nxt.hdr_ok = 1'b1;
            if (!st_r.hdr_ok)
            begin
              // a stray frame is dropped; keep waiting for the real answer
              st_nxt.rsp_err = 1'b1;
            end
            else
            begin
              st_nxt.fsm = amm_pkg::S_IDLE;
              // slot and subslot move only with an apply, so the record holds otherwise
              if (rsp_word == amm_pkg::ADAPT_USE_HOST)
              begin
                st_nxt.app = apply_rec(st_r.cur_info, st_r.mod_state, st_r.sub_state,
                  st_r.act_mod, st_r.act_sub);
              end
              else if (rsp_word == amm_pkg::ADAPT_PERFECT)
              begin
                // words 9 to 14 of the response are ignored here
                st_nxt.app = apply_rec(st_r.cur_info, amm_pkg::SLOT_CORRECT_UNIT, amm_pkg::SUBSLOT_CORRECT_UNIT,
                  st_r.cur_info.des_mod, st_r.cur_info.des_sub);
              end
              else
              begin
                // undefined choice: nothing applied
                st_nxt.rsp_err = 1'b1;
              end
            end
          end
        end
      end
      default: st_nxt.fsm = amm_pkg::S_IDLE;
    endcase

    // ******************************************************
    // register port
    // ******************************************************
    if (reg_wr)
    begin
      case (reg_addr)
        amm_pkg::OFF_CTRL: st_nxt.ctrl = reg_wdata[1:0];
        amm_pkg::OFF_REV_CNT: st_nxt.ident.rev_cnt = reg_wdata[15:0];
        amm_pkg::OFF_PROFILE: st_nxt.ident.profile = reg_wdata[15:0];
        amm_pkg::OFF_PROF_TYPE: st_nxt.ident.prof_type = reg_wdata[15:0];
        amm_pkg::OFF_IDENT_MASK: st_nxt.ident.ident_mask = reg_wdata[15:0];
        amm_pkg::OFF_REC_LEN: st_nxt.rec_len = reg_wdata[15:0];
        default: st_nxt.ctrl = st_nxt.ctrl;
      endcase
    end
    // ******************************************************
    // register read-back
    // ******************************************************
    if (reg_rd)
    begin
      case (reg_addr)
        amm_pkg::OFF_CTRL: st_nxt.rdata = {30'h0000_0000, st_r.ctrl};
        amm_pkg::OFF_REV_CNT: st_nxt.rdata = {16'h0000, st_r.ident.rev_cnt};
        amm_pkg::OFF_PROFILE: st_nxt.rdata = {16'h0000, st_r.ident.profile};
        amm_pkg::OFF_PROF_TYPE: st_nxt.rdata = {16'h0000, st_r.ident.prof_type};
        amm_pkg::OFF_IDENT_MASK: st_nxt.rdata = {16'h0000, st_r.ident.ident_mask};
        amm_pkg::OFF_REC_LEN: st_nxt.rdata = {16'h0000, st_r.rec_len};
        amm_pkg::OFF_STATUS:
        begin
          st_nxt.rdata[amm_pkg::ST_BUSY] = (st_r.fsm != amm_pkg::S_IDLE);
          st_nxt.rdata[amm_pkg::ST_PEND_ALARM] = st_r.pend_al;
          st_nxt.rdata[amm_pkg::ST_PEND_MISMATCH] = st_r.pend_mm;
          st_nxt.rdata[amm_pkg::ST_WAIT_RSP] = (st_r.fsm == amm_pkg::S_WAIT);
          st_nxt.rdata[amm_pkg::ST_RSP_ERR] = st_r.rsp_err;
        end
        amm_pkg::OFF_APPLIED: st_nxt.rdata = {st_r.app.mod_state, st_r.app.sub_state};
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ******************************************************
  // state register
  // ******************************************************
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st_r <= '0;
      st_r.fsm <= amm_pkg::S_IDLE;
      st_r.ctrl <= amm_pkg::CTRL_RST;
      st_r.ident.rev_cnt <= amm_pkg::REV_CNT_RST;
      st_r.ident.profile <= amm_pkg::PROFILE_RST;
      st_r.ident.prof_type <= amm_pkg::PROF_TYPE_RST;
      st_r.ident.ident_mask <= amm_pkg::IDENT_MASK_RST;
      st_r.rec_len <= amm_pkg::REC_LEN_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ******************************************************
  // outputs
  // ******************************************************
  assign reg_rdata = st_r.rdata;
  assign alarm_ack_ready = !st_r.pend_al;
  assign mismatch_ready = !st_r.pend_mm;
  assign tx_valid = st_r.tx_valid;
  assign tx_word = st_r.tx_word;
  assign rsp_ready = (st_r.fsm == amm_pkg::S_WAIT);
  assign applied = st_r.app;
  assign ident_record = st_r.ident;
  // substitution never rewrites the plugged length
  assign record_len = st_r.rec_len;

endmodule // amm_mailbox

`default_nettype wire

/* File: rtl/amm_pkg.sv */
// package: constants and carrier types for the mailbox indication engine
package amm_pkg;

  // ******************************************************
  // register offsets (byte addresses)
  // ******************************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_REV_CNT = 8'h04;
  localparam logic [7:0] OFF_PROFILE = 8'h08;
  localparam logic [7:0] OFF_PROF_TYPE = 8'h0C;
  localparam logic [7:0] OFF_IDENT_MASK = 8'h10;
  localparam logic [7:0] OFF_REC_LEN = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_APPLIED = 8'h1C;

  // ******************************************************
  // field positions
  // ******************************************************
  localparam int CTRL_ALARM_ACK_EN = 0;
  localparam int CTRL_MISMATCH_EN = 1;
  localparam int ST_BUSY = 0;
  localparam int ST_PEND_ALARM = 1;
  localparam int ST_PEND_MISMATCH = 2;
  localparam int ST_WAIT_RSP = 3;
  localparam int ST_RSP_ERR = 4;

  // ******************************************************
  // reset values
  // ******************************************************
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [15:0] REV_CNT_RST = 16'h0000;
  localparam logic [15:0] PROFILE_RST = 16'hF600;
  localparam logic [15:0] PROF_TYPE_RST = 16'h0004;
  localparam logic [15:0] IDENT_MASK_RST = 16'h001E;
  localparam logic [15:0] REC_LEN_RST = 16'h0000;

  // ******************************************************
  // frame layout and codes
  // ******************************************************
  localparam logic [3:0] FRAME_LAST = 4'hF;
  localparam logic [3:0] W_ID = 4'h0;
  localparam logic [3:0] W_INFO = 4'h1;
  localparam logic [3:0] W_CMD = 4'h2;
  localparam logic [3:0] W_MOD_STATE = 4'h9;
  localparam logic [3:0] W_SUB_STATE = 4'hA;
  localparam logic [3:0] W_ACT_MOD_HI = 4'hB;
  localparam logic [3:0] W_ACT_MOD_LO = 4'hC;
  localparam logic [3:0] W_ACT_SUB_HI = 4'hD;
  localparam logic [3:0] W_ACT_SUB_LO = 4'hE;
  localparam logic [15:0] MSG_INFO_IND = 16'h4002;
  localparam logic [15:0] MSG_INFO_RSP = 16'h0002;
  localparam logic [15:0] CMD_ALARM_ACK = 16'h0113;
  localparam logic [15:0] CMD_MISMATCH = 16'h0114;
  localparam logic [15:0] DATA_SIZE_NONE = 16'h0000;
  localparam logic [15:0] FRAME_ONE = 16'h0001;
  localparam logic [15:0] ADAPT_USE_HOST = 16'h0000;
  localparam logic [15:0] ADAPT_PERFECT = 16'h0001;
  localparam logic [15:0] SLOT_CORRECT_UNIT = 16'h0002;
  localparam logic [15:0] SUBSLOT_CORRECT_UNIT = 16'hFFFF;

  typedef enum {S_IDLE, S_SEND, S_WAIT} amm_fsm_t;

  typedef struct packed {
    logic [15:0] relationship_handle;
    logic [15:0] slot;
    logic [15:0] subslot;
    logic [31:0] des_mod;
    logic [31:0] des_sub;
  } amm_mismatch_t;

  typedef struct packed {
    logic valid;
    logic [15:0] slot;
    logic [15:0] subslot;
    logic [15:0] mod_state;
    logic [15:0] sub_state;
    logic [31:0] mod_id;
    logic [31:0] sub_id;
  } amm_apply_t;

  typedef struct packed {
    logic [15:0] rev_cnt;
    logic [15:0] profile;
    logic [15:0] prof_type;
    logic [15:0] ident_mask;
  } amm_ident_t;

endpackage

/* File: test/amm_properties.sv */
// checker: port-level properties of the mailbox indication engine
`timescale 1ns/1ps
`default_nettype none
module amm_properties
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  // controller events
  input wire logic alarm_ack_event,
  input wire logic alarm_ack_ready,
  input wire logic mismatch_event,
  input wire logic mismatch_ready,
  // streams and results
  input wire logic tx_valid,
  input wire logic [15:0] tx_word,
  input wire logic tx_ready,
  input wire amm_pkg::amm_apply_t applied,
  input wire amm_pkg::amm_ident_t ident_record,
  input wire logic [15:0] record_len
);
  // ******************************************************
  // shadow of the enables and the word position
  // ******************************************************
  logic [1:0] en_r;
  logic [3:0] wcnt_r;
  logic alarm_r;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      en_r <= 2'h0;
      wcnt_r <= 4'h0;
      alarm_r <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == amm_pkg::OFF_CTRL)
        en_r <= reg_wdata[1:0];
      if (tx_valid && tx_ready)
        wcnt_r <= wcnt_r + 4'h1;
      if (tx_valid && tx_ready && wcnt_r == 4'h2)
        alarm_r <= tx_word == 16'h0113;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence s_alarm_in;
    alarm_ack_event && alarm_ack_ready;
  endsequence
  sequence s_mm_in;
    mismatch_event && mismatch_ready;
  endsequence
  property p_mask_rst;
    $fell(reset) |-> ident_record.ident_mask == 16'h001E;
  endproperty
  a_mask_rst: assert property (p_mask_rst) else $error("ident mask reset value wrong");
  property p_prof_rst;
    $fell(reset) |-> ident_record[63:16] == 48'h0000_F600_0004;
  endproperty
  a_prof_rst: assert property (p_prof_rst) else $error("ident record reset value wrong");
  property p_alarm_take;
    s_alarm_in ##0 en_r[0] |=> !alarm_ack_ready;
  endproperty
  a_alarm_take: assert property (p_alarm_take) else $error("enabled alarm ack not taken");
  property p_alarm_drop;
    s_alarm_in ##0 !en_r[0] |=> alarm_ack_ready;
  endproperty
  a_alarm_drop: assert property (p_alarm_drop) else $error("disabled alarm ack taken");
  property p_mm_take;
    s_mm_in ##0 en_r[1] |=> !mismatch_ready;
  endproperty
  a_mm_take: assert property (p_mm_take) else $error("enabled mismatch not taken");
  property p_mm_drop;
    s_mm_in ##0 !en_r[1] |=> mismatch_ready;
  endproperty
  a_mm_drop: assert property (p_mm_drop) else $error("disabled mismatch taken");
  property p_info;
    tx_valid && wcnt_r == 4'h1 |-> tx_word == 16'h4002;
  endproperty
  a_info: assert property (p_info) else $error("message information word wrong");
  property p_cmd;
    tx_valid && wcnt_r == 4'h2 |-> tx_word inside {16'h0113, 16'h0114};
  endproperty
  a_cmd: assert property (p_cmd) else $error("command word wrong");
  property p_fixed;
    tx_valid && wcnt_r inside {[3:7]} |-> tx_word == ((wcnt_r inside {4, 5}) ? 16'h0001 : 16'h0000);
  endproperty
  a_fixed: assert property (p_fixed) else $error("size, count or offset word wrong");
  property p_zero;
    tx_valid && (wcnt_r == 4'hF || (alarm_r && wcnt_r > 4'h8)) |-> tx_word == 16'h0000;
  endproperty
  a_zero: assert property (p_zero) else $error("unused extended word not zero");
  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_word);
  endproperty
  a_hold: assert property (p_hold) else $error("tx word dropped before taken");
  property p_len;
    !(reg_wr && reg_addr == amm_pkg::OFF_REC_LEN) |=> $stable(record_len);
  endproperty
  a_len: assert property (p_len) else $error("record length moved by adaptation");
endmodule // amm_properties
bind amm_mailbox amm_properties u_props
(
  .clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .alarm_ack_event, .alarm_ack_ready, .mismatch_event,
  .mismatch_ready, .tx_valid, .tx_word, .tx_ready, .applied, .ident_record, .record_len
);
`default_nettype wire

/* File: test/amm_host_model.sv */
// partner: host application answering mismatch indications
`timescale 1ns/1ps
`default_nettype none
module amm_host_model
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // scenario controls
  input wire logic slow,
  input wire logic bad,
  input wire logic [15:0] mst,
  input wire logic [15:0] sst,
  input wire logic [15:0] ch,
  input wire logic [31:0] amod,
  input wire logic [31:0] asub,
  // indication stream
  input wire logic tx_valid,
  input wire logic [15:0] tx_word,
  output logic tx_ready,
  // response stream
  output logic rsp_valid,
  output logic [15:0] rsp_word,
  input wire logic rsp_ready
);
  logic [15:0] f [16];
  logic [15:0] r [16];
  int n = 0;
  int k = 0;
  int seed = 8865;
  bit busy = 0;
  always @(posedge clk)
  begin
    if (reset)
    begin
      tx_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_word <= 16'h0000;
      n = 0;
      busy = 0;
    end
    else
    begin
      tx_ready <= !slow || $random(seed) % 2 == 0;
      if (tx_valid && tx_ready)
      begin
        f[n] = tx_word;
        n = (n + 1) % 16;
        // alarm frames get no answer, only mismatches do
        if (n == 0 && f[2] == 16'h0114)
        begin
          r = '{f[0], bad ? 16'h4002 : 16'h0002, f[2], 16'h0000, 16'h0001, 16'h0001, 16'h0000, 16'h0000,
            16'h0000, mst, sst, amod[31:16], amod[15:0], asub[31:16], asub[15:0], ch};
          busy = 1;
          k = 0;
        end
      end
      if (busy && rsp_valid && rsp_ready)
        k++;
      // a broken header is followed by a correct resend
      if (k == 16)
      begin
        k = 0;
        busy = r[1] != 16'h0002;
        r[1] = 16'h0002;
      end
      rsp_valid <= busy;
      rsp_word <= busy ? r[k] : ~rsp_word;
    end
  end
endmodule // amm_host_model
`default_nettype wire

/* File: test/tb_top.sv */
// testbench: mailbox indication engine against a queue model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, ae = 0, me = 0, slow = 0, bad = 0;
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, amod = 0, asub = 0, d;
  logic [128:0] pa;
  logic [15:0] ah = 0, mst = 0, sst = 0, ch = 0, len, tx_word, rsp_word, record_len;
  amm_pkg::amm_mismatch_t mi = '0;
  amm_pkg::amm_apply_t applied;
  amm_pkg::amm_ident_t ident_record;
  logic alarm_ack_ready, mismatch_ready, tx_valid, tx_ready, rsp_valid, rsp_ready;
  int fail_count = 0, check_count = 0, seed = 8865, fid = 0;
  logic [15:0] txq [$];
  logic [15:0] hdr [8] = '{16'h0, 16'h4002, 16'h0, 16'h0, 16'h1, 16'h1, 16'h0, 16'h0};
  logic [15:0] ss [4] = '{16'h0000, 16'h0001, 16'h0007, 16'hFFFF};
  logic [7:0] ra [5] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h20};
  logic [31:0] rv [5] = '{32'h0, 32'hF600, 32'h4, 32'h1E, 32'h0};
  always #20 clk = ~clk;
  amm_mailbox u_dut
  (
    .clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .alarm_ack_event(ae), .alarm_ack_handle(ah), .alarm_ack_ready,
    .mismatch_event(me), .mismatch_info(mi), .mismatch_ready,
    .tx_valid, .tx_word, .tx_ready, .rsp_valid, .rsp_word, .rsp_ready,
    .applied, .ident_record, .record_len
  );
  amm_host_model u_host
  (
    .clk, .reset, .slow, .bad, .mst, .sst, .ch, .amod, .asub,
    .tx_valid, .tx_word, .tx_ready, .rsp_valid, .rsp_word, .rsp_ready
  );
  always @(posedge clk)
    if (!reset && tx_valid && tx_ready)
      txq.push_back(tx_word);
  // ******************************************************
  // shared tasks
  // ******************************************************
  task automatic test_done;
    if (fail_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [128:0] seen, input logic [128:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1;
    @(posedge clk);
    reg_wr <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge clk);
    reg_rd <= 0;
    #1 d = reg_rdata;
  endtask
  task automatic fire(input bit m);
    @(posedge clk);
    if (m)
      me <= 1;
    else
      ae <= 1;
    ah <= 16'($random(seed));
    mi <= {$random(seed), $random(seed), $random(seed), $random(seed)};
    @(posedge clk);
    me <= 0;
    ae <= 0;
  endtask
  // waits for a whole frame, or for the apply pulse when a is set
  task automatic await(input bit a);
    int i;
    for (i = 0; i < 400 && (a ? applied.valid !== 1'b1 : txq.size() < 16); i++)
    begin
      @(posedge clk);
      #1;
    end
    if (i == 400)
    begin
      fail_count++;
      test_done();
    end
  endtask
  task automatic frame(input logic [15:0] cmd, input logic [15:0] x [8]);
    await(0);
    fid++;
    for (int i = 0; i < 16; i++)
      chk("tx word", txq[i], i > 7 ? x[i - 8] : i == 0 ? fid : i == 2 ? cmd : hdr[i]);
    txq.delete();
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    reset <= 0;
    #1 chk("ident", ident_record, {16'h0000, 16'hF600, 16'h0004, 16'h001E});
    for (int i = 0; i < 5; i++)
    begin
      rd(ra[i]);
      chk("register", d, rv[i]);
    end
    // both indications start disabled
    fire(0);
    fire(1);
    repeat (4) @(posedge clk);
    chk("dropped", {txq.size(), alarm_ack_ready, mismatch_ready}, 34'h3);
    wr(8'h00, 32'h3);
    len = 16'($random(seed));
    wr(8'h14, {16'h0000, len});
    fire(0);
    frame(16'h0113, '{ah, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0});
    // four state pairs, then adaptation by the controller, then a bad header under stalls
    for (int j = 0; j < 6; j++)
    begin
      @(posedge clk);
      mst <= (j == 5) ? 16'h0003 : 16'(j % 4);
      sst <= ss[j % 4];
      amod <= $random(seed);
      asub <= $random(seed);
      ch <= (j == 4) ? 16'h0001 : 16'h0000;
      bad <= j == 5;
      slow <= j == 5;
      fire(1);
      frame(16'h0114, '{mi.relationship_handle, mi.slot, mi.subslot, mi.des_mod[31:16], mi.des_mod[15:0],
        mi.des_sub[31:16], mi.des_sub[15:0], 16'h0});
      await(1);
      pa = ch[0] ? {1'b1, mi.slot, mi.subslot, 16'h0002, 16'hFFFF, mi.des_mod, mi.des_sub}
        : {1'b1, mi.slot, mi.subslot, mst, sst, amod, asub};
      chk("applied", applied, pa);
      chk("record length", record_len, len);
    end
    rd(8'h18);
    chk("header error", d[4], 1'b1);
    wr(8'h18, 32'h10);
    rd(8'h18);
    chk("status", d, 32'h0);
    rd(8'h00);
    chk("control", d, 32'h3);
    rd(8'h14);
    chk("record length reg", d, {16'h0000, len});
    rd(8'h1C);
    chk("applied states", d, {mst, sst});
    // an undefined adaptation choice applies nothing and flags an error
    @(posedge clk);
    ch <= 16'h0002;
    bad <= 0;
    fire(1);
    frame(16'h0114, '{mi.relationship_handle, mi.slot, mi.subslot, mi.des_mod[31:16], mi.des_mod[15:0],
      mi.des_sub[31:16], mi.des_sub[15:0], 16'h0});
    repeat (24) @(posedge clk);
    #1 chk("applied held", applied, {1'b0, pa[127:0]});
    rd(8'h18);
    chk("undefined choice", d, 32'h10);
    test_done();
  end
endmodule // tb_top
`default_nettype wire
